//--- logic/scd_clock_divider.sv
`default_nettype none
// Contract
// - The source bit picks the Nyquist or high freq input, Nyquist at reset.
// - The high frequency input is divided by four before the integer divider.
// - The selected clock is divided by an integer ratio from 1 to 8.
// - One ratio register serves both clock sources.
// - Any ratio other than 1 forces the duty cycle stabilizer on.
// - Two sync bits enable resync, on every pulse or the first after a write.
// - An accepted reference pulse returns the dividers to initial state.
// - The stabilizer is bypassed while its loop is unlocked, as below 40 MHz.
module scd_clock_divider (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    input  wire logic       nyq_clk_in,
    input  wire logic       high_freq_clock_in,
    input  wire logic       sysref_in,
    input  wire logic       dcs_lock_in,
    output var  logic       sample_clk_ch_a,
    output var  logic       sample_clk_ch_b,
    output var  logic       duty_cycle_stabilizer_on,
    output var  logic       sync_armed
);

    function automatic logic wr_hit(input logic       en,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
        wr_hit = en && (addr == target);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: nyq, high freq, sysref, lock

    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [2:0] pin_prev_q;
    logic       nyq_s;
    logic       rf_s;
    logic       ref_s;
    logic       lock_s;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 3'h0;
        end else begin
            pin_meta_q <= {dcs_lock_in, sysref_in, high_freq_clock_in,
                           nyq_clk_in};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q[2:0];
        end
    end

    assign nyq_s  = pin_sync_q[0];
    assign rf_s   = pin_sync_q[1];
    assign ref_s  = pin_sync_q[2];
    assign lock_s = pin_sync_q[3];

    ////////////////////////////////////////////////////////////////////////
    // Registers and divider state

    scd_pkg::scd_cfg_t cfg_q, cfg_d;
    logic       armed_q, armed_d;
    logic [1:0] pre_cnt_q, pre_cnt_d;
    logic [2:0] div_cnt_q, div_cnt_d;
    logic       clk_out_q, clk_out_d;
    logic       dcs_on_q, dcs_on_d;
    logic [7:0] rdata_q, rdata_d;
    logic       wr_src;
    logic       wr_div;
    logic       wr_sync;
    logic       nyq_rise;
    logic       rf_rise;
    logic       ref_rise;
    logic       sel_rise;
    logic       sel_level;
    logic       sync_hit;
    logic [2:0] half;

    always_comb begin
        wr_src   = wr_hit(reg_wr_en, reg_addr, scd_pkg::ADDR_SRC_SEL);
        wr_div   = wr_hit(reg_wr_en, reg_addr, scd_pkg::ADDR_DIV_RATIO);
        wr_sync  = wr_hit(reg_wr_en, reg_addr, scd_pkg::ADDR_SYNC_CTL);
        nyq_rise = nyq_s && !pin_prev_q[0];
        rf_rise  = rf_s && !pin_prev_q[1];
        ref_rise = ref_s && !pin_prev_q[2];
        cfg_d    = cfg_q;
        armed_d  = armed_q;
        if (wr_src) begin
            cfg_d.rf_sel = reg_wdata[scd_pkg::SRC_RF_BIT];
            cfg_d.dcs_en = reg_wdata[scd_pkg::SRC_DCS_EN_BIT];
        end
        if (wr_div) begin
            cfg_d.ratio_m1 =
                reg_wdata[scd_pkg::DIV_MSB:scd_pkg::DIV_LSB];
        end
        // Predivide by four; its rising edge is the 01 to 10 step
        pre_cnt_d = rf_rise ? pre_cnt_q + 2'h1 : pre_cnt_q;
        sel_rise  = cfg_q.rf_sel ?
                    (rf_rise && pre_cnt_q == scd_pkg::PREDIV_RISE_CNT) :
                    nyq_rise;
        sel_level = cfg_q.rf_sel ? pre_cnt_q[1] : nyq_s;
        div_cnt_d = div_cnt_q;
        if (sel_rise) begin
            div_cnt_d = (div_cnt_q >= cfg_q.ratio_m1) ? scd_pkg::DIV_INIT :
                        div_cnt_q + 3'h1;
        end
        // Accept every pulse, or only the first after a write
        sync_hit = ref_rise && cfg_q.sync_en &&
                   (!cfg_q.sync_first || armed_q);
        if (sync_hit) begin
            pre_cnt_d = scd_pkg::PREDIV_INIT;
            div_cnt_d = scd_pkg::DIV_INIT;
            armed_d   = 1'b0;
        end
        if (wr_sync) begin
            cfg_d.sync_en    = reg_wdata[scd_pkg::SYNC_EN_BIT];
            cfg_d.sync_first = reg_wdata[scd_pkg::SYNC_FIRST_BIT];
            armed_d          = 1'b1;
        end
        half      = 3'((4'(cfg_q.ratio_m1) + 4'h1) >> 1);
        clk_out_d = (cfg_q.ratio_m1 == 3'h0) ? sel_level :
                    (div_cnt_d < half);
        dcs_on_d  = (cfg_q.dcs_en || cfg_q.ratio_m1 != 3'h0)
                    && lock_s;
        case (reg_addr)
            scd_pkg::ADDR_SRC_SEL: begin
                rdata_d = 8'h00;
                rdata_d[scd_pkg::SRC_RF_BIT]     = cfg_q.rf_sel;
                rdata_d[scd_pkg::SRC_DCS_EN_BIT] = cfg_q.dcs_en;
            end
            scd_pkg::ADDR_DIV_RATIO: begin
                rdata_d = {5'h00, cfg_q.ratio_m1};
            end
            scd_pkg::ADDR_SYNC_CTL: begin
                rdata_d = 8'h00;
                rdata_d[scd_pkg::SYNC_EN_BIT]    = cfg_q.sync_en;
                rdata_d[scd_pkg::SYNC_FIRST_BIT] = cfg_q.sync_first;
                rdata_d[scd_pkg::SYNC_ARMED_BIT] = armed_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg_q     <= scd_pkg::CFG_RST;
            armed_q   <= 1'b0;
            pre_cnt_q <= scd_pkg::PREDIV_INIT;
            div_cnt_q <= scd_pkg::DIV_INIT;
            clk_out_q <= 1'b0;
            dcs_on_q  <= 1'b0;
            rdata_q   <= 8'h00;
        end else begin
            cfg_q     <= cfg_d;
            armed_q   <= armed_d;
            pre_cnt_q <= pre_cnt_d;
            div_cnt_q <= div_cnt_d;
            clk_out_q <= clk_out_d;
            dcs_on_q  <= dcs_on_d;
            rdata_q   <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign sample_clk_ch_a          = clk_out_q;
    assign sample_clk_ch_b          = clk_out_q;
    assign duty_cycle_stabilizer_on = dcs_on_q;
    assign sync_armed               = armed_q;
    assign reg_rdata                = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_reset_nyq_sel: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(reset_n) |-> !cfg_q.rf_sel)
        else $error("Source not Nyquist after reset");

    a_src_write: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        wr_src |=> cfg_q.rf_sel == $past(reg_wdata[scd_pkg::SRC_RF_BIT]))
        else $error("Source select write lost");

    a_prediv_four: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (cfg_q.rf_sel && rf_rise && !sync_hit && !wr_src &&
         pre_cnt_q == 2'h3)
        |=> pre_cnt_q == 2'h0 && !sel_level)
        else $error("Predivider not dividing by four");

    a_div_wrap: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (sel_rise && div_cnt_q == cfg_q.ratio_m1 && !wr_div)
        |=> div_cnt_q == 3'h0)
        else $error("Divider did not wrap at ratio");

    a_shared_ratio: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        wr_div |=> cfg_q.ratio_m1 == $past(reg_wdata[2:0]))
        else $error("Ratio write lost");

    a_dcs_forced: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (cfg_q.ratio_m1 != 3'h0 && lock_s) |=> dcs_on_q)
        else $error("Stabilizer not forced on");

    a_sync_first: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (sync_hit && cfg_q.sync_first && !wr_sync) |=> !armed_q)
        else $error("First pulse mode did not disarm");

    a_sync_reset: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        sync_hit |=> div_cnt_q == 3'h0 && pre_cnt_q == 2'h0)
        else $error("Divider not reset by reference");

    a_dcs_bypass: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !lock_s |=> !dcs_on_q)
        else $error("Stabilizer on while unlocked");

    a_chan_same: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        sample_clk_ch_a == sample_clk_ch_b)
        else $error("Channel clocks differ");

endmodule : scd_clock_divider
`default_nettype wire

//--- logic/scd_pkg.sv
`default_nettype none
package scd_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_SRC_SEL   = 8'h09;
    localparam logic [7:0] ADDR_DIV_RATIO = 8'h0b;
    localparam logic [7:0] ADDR_SYNC_CTL  = 8'h3a;

    // Field positions
    localparam int SRC_RF_BIT     = 0;
    localparam int SRC_DCS_EN_BIT = 4;
    localparam int DIV_LSB        = 0;
    localparam int DIV_MSB        = 2;
    localparam int SYNC_EN_BIT    = 1;
    localparam int SYNC_FIRST_BIT = 2;
    localparam int SYNC_ARMED_BIT = 3;

    // Reset values
    localparam logic [7:0] SRC_SEL_RST   = 8'h00;
    localparam logic [7:0] DIV_RATIO_RST = 8'h00;
    localparam logic [7:0] SYNC_CTL_RST  = 8'h00;

    // Divider constants
    localparam logic [1:0] PREDIV_RISE_CNT = 2'h1;
    localparam logic [1:0] PREDIV_INIT     = 2'h0;
    localparam logic [2:0] DIV_INIT        = 3'h0;

    typedef struct packed {
        logic       rf_sel;
        logic       dcs_en;
        logic [2:0] ratio_m1;
        logic       sync_en;
        logic       sync_first;
    } scd_cfg_t;

    localparam scd_cfg_t CFG_RST = '{
        rf_sel:     SRC_SEL_RST[SRC_RF_BIT],
        dcs_en:     SRC_SEL_RST[SRC_DCS_EN_BIT],
        ratio_m1:   DIV_RATIO_RST[DIV_MSB:DIV_LSB],
        sync_en:    SYNC_CTL_RST[SYNC_EN_BIT],
        sync_first: SYNC_CTL_RST[SYNC_FIRST_BIT]
    };

endpackage : scd_pkg
`default_nettype wire

//--- testbench/scd_clk_src_model.sv
`default_nettype none
module scd_clk_src_model (
    input  wire logic sys_clk,
    input  wire logic ref_req,
    input  wire logic lock_req,
    output var  logic nyq_clk_in         = 1'b0,
    output var  logic high_freq_clock_in = 1'b0,
    output var  logic sysref_in          = 1'b0,
    output var  logic dcs_lock_in        = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] nc = 2'h0, hc = 2'h0;
    logic [2:0] rc = 3'h0;
    // Free clocks below a quarter of sys_clk, reference pulse of 4 cycles
    always @(posedge sys_clk) begin
        nc <= nc + 2'h1;
        hc <= (hc == 2'h2) ? 2'h0 : hc + 2'h1;
        nyq_clk_in <= nyq_clk_in ^ (nc == 2'h3);
        high_freq_clock_in <= high_freq_clock_in ^ (hc == 2'h2);
        rc <= ref_req ? 3'h4 : rc - {2'h0, rc != 3'h0};
        sysref_in <= ref_req || rc > 3'h1;
        dcs_lock_in <= lock_req;
    end
endmodule : scd_clk_src_model
`default_nettype wire

//--- testbench/test_sample_clock_select_divider.sv
`default_nettype none
module test_sample_clock_select_divider;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0;
    logic       ref_req = 1'b0, lock_req = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       nyq_clk_in, high_freq_clock_in, sysref_in, dcs_lock_in;
    logic       sample_clk_ch_a, sample_clk_ch_b;
    logic       duty_cycle_stabilizer_on, sync_armed;
    int         n_fail = 0, cmp_count = 0, p;
    always #25 sys_clk = !sys_clk;
    scd_clock_divider scd_clock_divider_i (.sys_clk, .reset_n, .reg_wr_en,
        .reg_addr, .reg_wdata, .reg_rdata, .nyq_clk_in, .high_freq_clock_in,
        .sysref_in, .dcs_lock_in, .sample_clk_ch_a, .sample_clk_ch_b,
        .duty_cycle_stabilizer_on, .sync_armed);
    scd_clk_src_model scd_clk_src_model_i (.sys_clk, .ref_req, .lock_req,
        .nyq_clk_in, .high_freq_clock_in, .sysref_in, .dcs_lock_in);
    task automatic chk(input string nm, input logic [15:0] e, g);
        cmp_count++;
        n_fail += int'(g !== e);
        if (g !== e)
            $display("Error %s expected %h seen %h", nm, e, g);
    endtask : chk
    task automatic conclude;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr_en} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        @(posedge sys_clk) reg_addr <= a;
        repeat (2) @(posedge sys_clk) #1;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask : rd
    // Wait for the channel A clock to change to level v, bounded
    task automatic await(input logic v);
        logic pv = sample_clk_ch_a;
        repeat (1500) begin
            @(posedge sys_clk) #1;
            if (sample_clk_ch_b !== sample_clk_ch_a)
                chk("ch_b", 16'(sample_clk_ch_a), 16'(sample_clk_ch_b));
            if (pv === !v && sample_clk_ch_a === v)
                return;
            pv = sample_clk_ch_a;
        end
        chk("sample clock edge", 16'h1, 16'h0);
        conclude();
    endtask : await
    task automatic meas(output int q);
        await(1'b1);
        q = -int'($time / 50);
        await(1'b1);
        q += int'($time / 50);
    endtask : meas
    task automatic duty_cycle_stabilizer(input logic [7:0] s, r, input logic l, e);
        wr(scd_pkg::ADDR_SRC_SEL, s);
        wr(scd_pkg::ADDR_DIV_RATIO, r);
        lock_req <= l;
        repeat (8) @(posedge sys_clk) #1;
        chk("dcs_on", {15'h0, e}, {15'h0, duty_cycle_stabilizer_on});
    endtask : duty_cycle_stabilizer
    // Pulse the reference just after a fall and look for an early rise
    task automatic syn(input logic e);
        logic hi = 1'b0;
        await(1'b0);
        @(posedge sys_clk) ref_req <= 1'b1;
        @(posedge sys_clk) ref_req <= 1'b0;
        repeat (12) @(posedge sys_clk) #1 hi |= sample_clk_ch_a;
        chk("resync", {15'h0, e}, {15'h0, hi});
    endtask : syn
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(scd_pkg::ADDR_SRC_SEL, 8'h00);
        rd(scd_pkg::ADDR_DIV_RATIO, 8'h00);
        rd(scd_pkg::ADDR_SYNC_CTL, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        for (int r = 1; r <= 8; r++) begin
            wr(scd_pkg::ADDR_DIV_RATIO, 8'(r - 1));
            rd(scd_pkg::ADDR_DIV_RATIO, 8'(r - 1));
            meas(p);
            chk("nyq period", 16'(8 * r), 16'(p));
        end
        wr(scd_pkg::ADDR_SRC_SEL, 8'h01);
        wr(scd_pkg::ADDR_DIV_RATIO, 8'h02);
        meas(p);
        chk("rf period", 16'h48, 16'(p));
        wr(scd_pkg::ADDR_DIV_RATIO, 8'h00);
        meas(p);
        chk("rf period", 16'h18, 16'(p));
        $display("Test registers and divider done");
        duty_cycle_stabilizer(8'h00, 8'h00, 1'b1, 1'b0);
        duty_cycle_stabilizer(8'h00, 8'h01, 1'b1, 1'b1);
        duty_cycle_stabilizer(8'h10, 8'h00, 1'b1, 1'b1);
        duty_cycle_stabilizer(8'h00, 8'h07, 1'b0, 1'b0);
        syn(1'b0);
        wr(scd_pkg::ADDR_SYNC_CTL, 8'h02);
        syn(1'b1);
        syn(1'b1);
        wr(scd_pkg::ADDR_SYNC_CTL, 8'h06);
        rd(scd_pkg::ADDR_SYNC_CTL, 8'h0e);
        chk("sync_armed", 16'h1, {15'h0, sync_armed});
        syn(1'b1);
        chk("sync_armed", 16'h0, {15'h0, sync_armed});
        rd(scd_pkg::ADDR_SYNC_CTL, 8'h06);
        syn(1'b0);
        $display("Test stabilizer and sync done");
        conclude();
    end
endmodule : test_sample_clock_select_divider
`default_nettype wire
